// ===== inc/lvic_pkg.sv
// shared constants, tables and types for the level/vector interrupt controller
package lvic_pkg;

   // structure sizes
   localparam int NUM_SRC   = 24;            // sources, index 23 is the reset source
   localparam int NUM_IRQ   = 23;            // sources that go through the levels
   localparam int NUM_VEC   = 17;            // level vectors, reset vector not counted
   localparam int NUM_LEVEL = 8;             // levels 0..7
   localparam int VEC_MAX   = 128;           // architectural ceiling of vectors per level

   // register byte offsets on the avalon slave
   localparam logic [7:0] OFS_LEVEL_MASK = 8'h00;   // level_mask_register
   localparam logic [7:0] OFS_LEVEL_PRIO = 8'h04;   // level_priority_register
   localparam logic [7:0] OFS_LEVEL_REQ  = 8'h08;   // level request bits, read only
   localparam logic [7:0] OFS_SYS_MODE   = 8'h0c;   // system_mode_register
   localparam logic [7:0] OFS_SRC_PEND   = 8'h10;   // per-source pending, write one clears
   localparam logic [7:0] OFS_INT_STAT   = 8'h14;   // sticky status, write one clears
   localparam logic [7:0] OFS_INT_MASK   = 8'h18;   // status mask
   localparam logic [7:0] OFS_TIMER2     = 8'he8;   // timer2_control

   // field positions
   localparam int GLB_EN_BIT      = 0;       // system_mode_register global enable
   localparam int T2_MC_PEND_BIT  = 0;       // timer2 match/capture pending
   localparam int T2_MC_EN_BIT    = 1;       // timer2 match/capture enable
   localparam int T2_OVF_EN_BIT   = 2;       // timer2 counter_wrap_event enable
   localparam int ST_GRANT_BIT    = 0;       // a request was granted
   localparam int ST_ISR_BIT      = 1;       // a service address was delivered
   localparam int ST_T2MC_BIT     = 2;       // timer2 match/capture event seen
   localparam int STAT_W          = 3;       // status width

   // reset values
   localparam logic [7:0] T2_RESET    = 8'h00;
   localparam logic [7:0] MASK_RESET  = 8'h00;
   localparam logic [7:0] PRIO_RESET  = 8'h00;

   // named sources
   localparam int SRC_T2_MATCH = 5;
   localparam int SRC_T2_WRAP  = 6;
   localparam int SRC_RESET    = 23;

   // vector addresses, index 16 down to 0
   localparam logic [NUM_VEC-1:0][7:0] VEC_ADDR = {
      8'hd0, 8'hd2, 8'hd4, 8'hd6, 8'hd8, 8'he0, 8'he2, 8'he4, 8'he6,
      8'he8, 8'hf0, 8'hf2, 8'hec, 8'hf4, 8'hf6, 8'hfa, 8'hfc};
   // level of each vector, index 16 down to 0
   localparam logic [NUM_VEC-1:0][2:0] VEC_LEVEL = {
      3'h4, 3'h4, 3'h4, 3'h4, 3'h5, 3'h6, 3'h6, 3'h6, 3'h6,
      3'h7, 3'h3, 3'h3, 3'h2, 3'h1, 3'h1, 3'h0, 3'h0};
   // vector of each level source, index 22 down to 0
   localparam logic [NUM_IRQ-1:0][4:0] SRC_VEC = {
      5'h10, 5'h0f, 5'h0e, 5'h0d, 5'h0c, 5'h0c, 5'h0c, 5'h0c,
      5'h0b, 5'h0a, 5'h09, 5'h08, 5'h07, 5'h07, 5'h07, 5'h07,
      5'h06, 5'h05, 5'h04, 5'h03, 5'h02, 5'h01, 5'h00};
   // sources whose pending bit hardware clears on grant
   localparam logic [NUM_IRQ-1:0] HW_CLR = 23'h00005a;

   // service sequencer
   typedef enum logic [1:0] {
      SVC_IDLE     = 2'b00,
      SVC_FETCH_HI = 2'b01,
      SVC_FETCH_LO = 2'b10
   } svc_state_e;

   // registered arbitration result
   typedef struct packed {
      logic       valid;
      logic [2:0] level;
      logic [4:0] vidx;
   } cand_s;

   // delivered service routine address
   typedef struct packed {
      logic        valid;
      logic [15:0] addr;
   } isr_s;

endpackage

// ===== rtl/level_arbiter.sv
// level arbiter: ranks requesting levels by group and subgroup settings
`timescale 1ns/1ns
`default_nettype none
module level_arbiter
   import lvic_pkg::*;
(
   // requests and ranking
   input  wire logic [7:0] i_req,
   input  wire logic [7:0] i_prio,
   // winner
   output logic            o_valid,
   output logic [2:0]      o_level
);

   // two-way pick, b first when b_first set
   function automatic logic [3:0] pick(input logic [3:0] a, input logic [3:0] b, input logic b_first);
      if (b_first) begin
         pick = b[3] ? b : a;
      end else begin
         pick = a[3] ? a : b;
      end
   endfunction

   logic [3:0] win_a;        // group a: levels 0,1
   logic [3:0] win_b34;      // subgroup 3,4
   logic [3:0] win_b;        // group b: levels 2,3,4
   logic [3:0] win_c67;      // subgroup 6,7
   logic [3:0] win_c;        // group c: levels 5,6,7
   logic [3:0] win;          // overall

   // subgroup then group order, all from the priority register
   always_comb begin
      win_a   = pick({i_req[0], 3'h0}, {i_req[1], 3'h1}, i_prio[3]);
      win_b34 = pick({i_req[3], 3'h3}, {i_req[4], 3'h4}, i_prio[5]);
      win_b   = pick({i_req[2], 3'h2}, win_b34, i_prio[4]);
      win_c67 = pick({i_req[6], 3'h6}, {i_req[7], 3'h7}, i_prio[7]);
      win_c   = pick({i_req[5], 3'h5}, win_c67, i_prio[6]);
      case (i_prio[2:0])
         3'h1:    win = pick(win_a, pick(win_c, win_b, 1'b0), 1'b0);   // a > c > b
         3'h2:    win = pick(win_b, pick(win_a, win_c, 1'b0), 1'b0);   // b > a > c
         3'h3:    win = pick(win_b, pick(win_c, win_a, 1'b0), 1'b0);   // b > c > a
         3'h4:    win = pick(win_c, pick(win_a, win_b, 1'b0), 1'b0);   // c > a > b
         3'h5:    win = pick(win_c, pick(win_b, win_a, 1'b0), 1'b0);   // c > b > a
         default: win = pick(win_a, pick(win_b, win_c, 1'b0), 1'b0);   // a > b > c
      endcase
      o_valid = win[3];
      o_level = win[2:0];
   end

endmodule // level_arbiter
`default_nettype wire

// ===== rtl/level_vector_interrupt_ctrl.sv
// level/vector interrupt controller with timer2 interrupt bits and avalon registers
//
// Overview of operation
// - eight levels, each source except reset on one level
// - level order comes from priority register
// - group and subgroup ranking between levels
// - levels hold zero to 128 vectors
// - lowest vector address wins within level
// - 24 sources, eighteen vectors, two shared
// - single, shared and multi vector levels
// - pending cleared by hardware or software
// - grant disables interrupts, pushes context
// - service address from two vector bytes
// - timer2 bit2 wrap, bit1 match enables
// - timer2 bit0 pending, write zero clears
// - wrap self clears, match cleared by software
// - timer2 control resets to zero
// - level mask gates each level
// - global enable set/cleared by instructions
//
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module level_vector_interrupt_ctrl
   import lvic_pkg::*;
#(
   parameter int NUM_SOURCES = NUM_SRC
)(
   // clock and reset
   input  wire logic                   i_mclk,
   input  wire logic                   i_nrst,
   // avalon-mm slave
   input  wire logic [7:0]             i_avs_address,
   input  wire logic                   i_avs_read,
   input  wire logic                   i_avs_write,
   input  wire logic [31:0]            i_avs_writedata,
   output logic [31:0]                 o_avs_readdata,
   output logic                        o_avs_waitrequest,
   // interrupt sources, one-cycle event pulses
   input  wire logic [NUM_SOURCES-1:0] i_src_event,
   // core instructions
   input  wire logic                   i_ei,
   input  wire logic                   i_di,
   // core request and accept
   output logic                        o_core_req,
   output logic [2:0]                  o_core_level,
   output logic [7:0]                  o_core_vector,
   input  wire logic                   i_core_ack,
   output logic                        o_push_ctx,
   // vector table fetch, combinational read
   output logic [7:0]                  o_rom_addr,
   input  wire logic [7:0]             i_rom_data,
   output isr_s                        o_isr,
   // reset source and interrupt line
   output logic                        o_sys_reset_req,
   output logic                        o_irq
);

   // lowest-address active vector on a level
   function automatic logic [4:0] lowest_vec(input logic [NUM_VEC-1:0] act, input logic [2:0] lvl);
      logic [7:0] best;
      lowest_vec = 5'h00;
      best = 8'hff;
      for (int v = 0; v < NUM_VEC; v++) begin
         if (act[v] && VEC_LEVEL[v] == lvl && VEC_ADDR[v] <= best) begin
            best = VEC_ADDR[v];
            lowest_vec = 5'(v);
         end
      end
   endfunction

   // register state
   logic [7:0]         level_mask, next_level_mask;      // per-level enable
   logic [7:0]         level_prio, next_level_prio;      // level ranking
   logic               glb_en, next_glb_en;              // global enable
   logic [NUM_IRQ-1:0] pend, next_pend;                  // per-source pending
   logic [2:0]         t2_en, next_t2_en;                // timer2 control bits 2..1 enables, bit 0 held zero
   logic [7:0]         t2_hi, next_t2_hi;                // timer2 clock/mode bits, stored only
   logic [STAT_W-1:0]  stat, next_stat;                  // sticky status
   logic [STAT_W-1:0]  stat_mask, next_stat_mask;        // status mask
   logic               bus_ack, next_bus_ack;            // second bus cycle
   logic [31:0]        rdata, next_rdata;                // read data
   // service state
   svc_state_e         state, next_state;
   cand_s              cand, next_cand;                  // registered winner
   logic [7:0]         vec, next_vec;                    // vector being fetched
   logic [7:0]         isr_hi, next_isr_hi;              // high address byte
   isr_s               isr, next_isr;
   logic               push, next_push;
   logic               rst_req, next_rst_req;
   logic [7:0]         rom_addr, next_rom_addr;
   // combinational terms
   logic [NUM_IRQ-1:0] src_en;                           // source enables
   logic [NUM_VEC-1:0] vec_act;                          // vectors with a live request
   logic [7:0]         level_req;                        // masked level requests
   logic               arb_valid;
   logic [2:0]         arb_level;
   logic               wr_acc, rd_acc;                   // accepted bus access
   logic               grant;                            // core accepted request
   logic [31:0]        pend_clr;                         // software clear bits

   // ranking between levels
   level_arbiter u_arb (
      .i_req   (level_req),
      .i_prio  (level_prio),
      .o_valid (arb_valid),
      .o_level (arb_level)
   );

   // bus handshake: one wait cycle, then answer
   assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~bus_ack;
   assign wr_acc = i_avs_write & bus_ack;
   assign rd_acc = i_avs_read & bus_ack;
   assign grant  = o_core_req & i_core_ack;
   assign pend_clr = wr_acc && i_avs_address == OFS_SRC_PEND ? i_avs_writedata : 32'h0;

   // request gathering, source to vector to level
   always_comb begin
      src_en = '1;
      src_en[SRC_T2_MATCH] = t2_en[T2_MC_EN_BIT];
      src_en[SRC_T2_WRAP]  = t2_en[T2_OVF_EN_BIT];
      vec_act = '0;
      for (int s = 0; s < NUM_IRQ; s++) begin
         if (pend[s] && src_en[s]) begin
            vec_act[SRC_VEC[s]] = 1'b1;
         end
      end
      level_req = '0;
      for (int v = 0; v < NUM_VEC; v++) begin
         if (vec_act[v]) begin
            level_req[VEC_LEVEL[v]] = 1'b1;
         end
      end
      level_req = level_req & level_mask;
   end

   // register file next values
   always_comb begin
      next_level_mask = level_mask;
      next_level_prio = level_prio;
      next_t2_en      = t2_en;
      next_t2_hi      = t2_hi;
      next_stat_mask  = stat_mask;
      next_bus_ack    = (i_avs_read | i_avs_write) & ~bus_ack;
      next_rdata      = rdata;
      next_glb_en     = glb_en;
      // writes land on the answering edge
      if (wr_acc) begin
         case (i_avs_address)
            OFS_LEVEL_MASK: next_level_mask = i_avs_writedata[7:0];
            OFS_LEVEL_PRIO: next_level_prio = i_avs_writedata[7:0];
            OFS_SYS_MODE:   next_glb_en     = i_avs_writedata[GLB_EN_BIT];
            OFS_INT_MASK:   next_stat_mask  = i_avs_writedata[STAT_W-1:0];
            OFS_TIMER2: begin
               next_t2_hi = {i_avs_writedata[7:3], 3'h0};
               next_t2_en = {i_avs_writedata[T2_OVF_EN_BIT], i_avs_writedata[T2_MC_EN_BIT], 1'b0};
            end
            default: ;                                   // unmapped or read-only: ignored
         endcase
      end
      // instructions and grant steer the global enable
      if (i_ei) begin
         next_glb_en = 1'b1;
      end
      if (i_di) begin
         next_glb_en = 1'b0;
      end
      if (grant) begin
         next_glb_en = 1'b0;
      end
      // read data captured in the wait cycle
      if ((i_avs_read) && !bus_ack) begin
         case (i_avs_address)
            OFS_LEVEL_MASK: next_rdata = {24'h0, level_mask};
            OFS_LEVEL_PRIO: next_rdata = {24'h0, level_prio};
            OFS_LEVEL_REQ:  next_rdata = {24'h0, level_req};
            OFS_SYS_MODE:   next_rdata = {31'h0, glb_en};
            OFS_SRC_PEND:   next_rdata = {9'h0, pend};
            OFS_INT_STAT:   next_rdata = {29'h0, stat};
            OFS_INT_MASK:   next_rdata = {29'h0, stat_mask};
            OFS_TIMER2:     next_rdata = {24'h0, t2_hi[7:3], t2_en[2:1], pend[SRC_T2_MATCH]};
            default:        next_rdata = 32'h0;          // unmapped reads as zero
         endcase
      end
   end

   // pending bits: set wins over every clear
   always_comb begin
      for (int s = 0; s < NUM_IRQ; s++) begin
         next_pend[s] = pend[s];
         if (pend_clr[s]) begin
            next_pend[s] = 1'b0;                         // software clear
         end
         if (grant && HW_CLR[s] && SRC_VEC[s] == cand.vidx) begin
            next_pend[s] = 1'b0;                         // hardware clear on grant
         end
         if (i_src_event[s]) begin
            next_pend[s] = 1'b1;
         end
      end
      // timer2 write of zero to bit0 clears the match pending, one does nothing
      if (wr_acc && i_avs_address == OFS_TIMER2 && !i_avs_writedata[T2_MC_PEND_BIT]
          && !i_src_event[SRC_T2_MATCH]) begin
         next_pend[SRC_T2_MATCH] = 1'b0;
      end
   end

   // sticky status with write-one clear, set wins
   always_comb begin
      next_stat = stat;
      if (wr_acc && i_avs_address == OFS_INT_STAT) begin
         next_stat = stat & ~i_avs_writedata[STAT_W-1:0];
      end
      if (grant) begin
         next_stat[ST_GRANT_BIT] = 1'b1;
      end
      if (isr.valid) begin
         next_stat[ST_ISR_BIT] = 1'b1;
      end
      if (i_src_event[SRC_T2_MATCH]) begin
         next_stat[ST_T2MC_BIT] = 1'b1;
      end
   end

   // service sequencer: grant, then two vector bytes
   always_comb begin
      next_state    = state;
      next_vec      = vec;
      next_isr_hi   = isr_hi;
      next_rom_addr = rom_addr;
      next_isr      = '0;
      next_push     = 1'b0;
      next_rst_req  = i_src_event[SRC_RESET];
      next_cand.valid = arb_valid;
      next_cand.level = arb_level;
      next_cand.vidx  = lowest_vec(vec_act, arb_level);
      case (state)
         SVC_IDLE: begin
            if (grant) begin
               next_vec      = VEC_ADDR[cand.vidx];
               next_rom_addr = VEC_ADDR[cand.vidx];
               next_push     = 1'b1;
               next_state    = SVC_FETCH_HI;
            end
         end
         SVC_FETCH_HI: begin
            next_isr_hi   = i_rom_data;                  // byte at vector address
            next_rom_addr = vec + 8'h01;
            next_state    = SVC_FETCH_LO;
         end
         SVC_FETCH_LO: begin
            next_isr.valid = 1'b1;
            next_isr.addr  = {isr_hi, i_rom_data};
            next_state     = SVC_IDLE;
         end
         default: next_state = SVC_IDLE;
      endcase
   end

   // all state registers
   always_ff @(posedge i_mclk) begin
      if (!i_nrst) begin
         level_mask <= MASK_RESET;
         level_prio <= PRIO_RESET;
         glb_en     <= 1'b0;                             // software must enable
         pend       <= '0;
         t2_en      <= T2_RESET[2:0];
         t2_hi      <= T2_RESET;
         stat       <= '0;
         stat_mask  <= '0;
         bus_ack    <= 1'b0;
         rdata      <= 32'h0;
         state      <= SVC_IDLE;
         cand       <= '0;
         vec        <= 8'h00;
         isr_hi     <= 8'h00;
         isr        <= '0;
         push       <= 1'b0;
         rst_req    <= 1'b0;
         rom_addr   <= 8'h00;
      end else begin
         level_mask <= next_level_mask;
         level_prio <= next_level_prio;
         glb_en     <= next_glb_en;
         pend       <= next_pend;
         t2_en      <= next_t2_en;
         t2_hi      <= next_t2_hi;
         stat       <= next_stat;
         stat_mask  <= next_stat_mask;
         bus_ack    <= next_bus_ack;
         rdata      <= next_rdata;
         state      <= next_state;
         cand       <= next_cand;
         vec        <= next_vec;
         isr_hi     <= next_isr_hi;
         isr        <= next_isr;
         push       <= next_push;
         rst_req    <= next_rst_req;
         rom_addr   <= next_rom_addr;
      end
   end

   // outputs
   // the winner is one cycle old, so the live mask gates it again to stop a freshly masked level
   assign o_core_req      = cand.valid & glb_en & level_mask[cand.level] & (state == SVC_IDLE);
   assign o_core_level    = cand.level;
   assign o_core_vector   = VEC_ADDR[cand.vidx];
   assign o_push_ctx      = push;
   assign o_rom_addr      = rom_addr;
   assign o_isr           = isr;
   assign o_avs_readdata  = rdata;
   assign o_sys_reset_req = rst_req;
   assign o_irq           = |(stat & stat_mask);

   // checks
   property p_grant_disable;
      @(posedge i_mclk) disable iff (!i_nrst) grant |=> (!glb_en && o_push_ctx);
   endproperty
   a_grant_disable: assert property (p_grant_disable) else $error("grant did not disable");

   property p_fetch;
      @(posedge i_mclk) disable iff (!i_nrst)
         grant |=> (o_rom_addr == $past(o_core_vector)) ##1 (o_rom_addr == $past(o_rom_addr) + 8'h01) ##1 o_isr.valid;
   endproperty
   a_fetch: assert property (p_fetch) else $error("vector fetch out of step");

   property p_no_req_disabled;
      @(posedge i_mclk) disable iff (!i_nrst) !glb_en |-> !o_core_req;
   endproperty
   a_no_req_disabled: assert property (p_no_req_disabled) else $error("request while disabled");

   property p_level_mask;
      @(posedge i_mclk) disable iff (!i_nrst) o_core_req |-> level_mask[o_core_level];
   endproperty
   a_level_mask: assert property (p_level_mask) else $error("masked level requested");

   property p_wrap_autoclr;
      @(posedge i_mclk) disable iff (!i_nrst)
         (grant && o_core_vector == VEC_ADDR[SRC_VEC[SRC_T2_WRAP]] && !i_src_event[SRC_T2_WRAP]) |=> !pend[SRC_T2_WRAP];
   endproperty
   a_wrap_autoclr: assert property (p_wrap_autoclr) else $error("wrap pending not cleared");

   property p_match_stays;
      @(posedge i_mclk) disable iff (!i_nrst)
         (pend[SRC_T2_MATCH] && !wr_acc) |=> pend[SRC_T2_MATCH];
   endproperty
   a_match_stays: assert property (p_match_stays) else $error("match pending lost");

   property p_t2_write0;
      @(posedge i_mclk) disable iff (!i_nrst)
         (wr_acc && i_avs_address == OFS_TIMER2 && !i_avs_writedata[0] && !i_src_event[SRC_T2_MATCH])
         |=> !pend[SRC_T2_MATCH];
   endproperty
   a_t2_write0: assert property (p_t2_write0) else $error("match pending not cleared");

   property p_t2_enable;
      @(posedge i_mclk) disable iff (!i_nrst)
         (pend[SRC_T2_MATCH] && !t2_en[T2_MC_EN_BIT]) |-> !vec_act[SRC_VEC[SRC_T2_MATCH]];
   endproperty
   a_t2_enable: assert property (p_t2_enable) else $error("disabled match requested");

   c_grant:  cover property (@(posedge i_mclk) disable iff (!i_nrst) grant);
   c_isr:    cover property (@(posedge i_mclk) disable iff (!i_nrst) o_isr.valid);
   c_t2clr:  cover property (@(posedge i_mclk) disable iff (!i_nrst) pend[SRC_T2_MATCH] ##1 !pend[SRC_T2_MATCH]);

endmodule // level_vector_interrupt_ctrl
`default_nettype wire

// ===== dv/core_model.sv
// core and vector rom model on the far side of the controller
`timescale 1ns/1ns
`default_nettype none
module core_model (
   // clock and mode
   input  wire logic       i_mclk,
   input  wire logic       i_slow,
   // request handshake
   input  wire logic       i_core_req,
   output logic            o_core_ack,
   // vector table
   input  wire logic [7:0] i_rom_addr,
   output logic [7:0]      o_rom_data
);
   int wait_cnt = 0;   // cycles a request has waited
   // byte pattern differs at every address, so a swapped pair shows
   assign o_rom_data = {i_rom_addr[3:0], ~i_rom_addr[7:4]};
   // accept at once, or after three cycles when slow; one-cycle ack
   always @(posedge i_mclk) begin
      wait_cnt <= (i_core_req && !o_core_ack) ? wait_cnt + 1 : 0;
      o_core_ack <= i_core_req && !o_core_ack && (!i_slow || wait_cnt >= 3);
   end
endmodule // core_model
`default_nettype wire

// ===== dv/testbench.sv
// self-checking bench for the level/vector interrupt controller
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import lvic_pkg::*;
   typedef struct {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] q;} row_s;
   logic        mclk = 0, nrst = 0, rd = 0, wr = 0, ei = 0, di = 0, slow = 0;   // bench drives
   logic [7:0]  addr = '0;
   logic [31:0] wdata = '0, rdata, q;
   logic [23:0] ev = '0;
   logic        wreq, req, ack, push, sysrst, irq;                       // design and core model outputs
   logic [2:0]  lvl;
   logic [7:0]  vec, raddr, rdat;
   isr_s        isr;
   int          num_errors = 0, checked = 0, cycles = 0;
   // register rows: optional write, then read and compare
   row_s rows[8] = '{
      '{0, OFS_TIMER2, 0, 32'h0}, '{0, OFS_LEVEL_MASK, 0, 32'h0},
      '{1, OFS_TIMER2, 32'hff, 32'hfe}, '{1, 8'h40, 32'hff, 32'h0},
      '{1, OFS_LEVEL_REQ, 32'hff, 32'h0}, '{1, OFS_LEVEL_PRIO, 32'h04, 32'h04},
      '{1, OFS_INT_MASK, 32'h04, 32'h04}, '{1, OFS_TIMER2, 32'h06, 32'h06}};
   level_vector_interrupt_ctrl dut_u (.i_mclk(mclk), .i_nrst(nrst), .i_avs_address(addr),
      .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata), .o_avs_readdata(rdata),
      .o_avs_waitrequest(wreq), .i_src_event(ev), .i_ei(ei), .i_di(di), .o_core_req(req),
      .o_core_level(lvl), .o_core_vector(vec), .i_core_ack(ack), .o_push_ctx(push),
      .o_rom_addr(raddr), .i_rom_data(rdat), .o_isr(isr), .o_sys_reset_req(sysrst), .o_irq(irq));
   core_model core_u (.i_mclk(mclk), .i_slow(slow), .i_core_req(req), .o_core_ack(ack),
      .i_rom_addr(raddr), .o_rom_data(rdat));
   // clock, 100 ns period
   initial begin
      forever #50 mclk = ~mclk;
   end
   // hang guard
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         give_verdict();
      end
   end
   function automatic logic [7:0] rom(input logic [7:0] b);
      return {b[3:0], ~b[7:4]};
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one avalon transfer, held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      addr <= a;
      wdata <= d;
      wr <= w;
      rd <= !w;
      @(posedge mclk);
      while (wreq !== 1'b0) @(posedge mclk);
      q = rdata;
      wr <= 0;
      rd <= 0;
      @(posedge mclk);
   endtask
   task automatic pulse(input logic [23:0] m, input logic e);
      ev <= m;
      ei <= e;
      @(posedge mclk);
      ev <= '0;
      ei <= 0;
      @(posedge mclk);
   endtask
   // enable, wait for request, let the core take it, check the fetched address
   task automatic service(input logic [2:0] l, input logic [7:0] v);
      pulse('0, 1);
      for (int n = 0; n < 20 && req !== 1'b1; n++) @(posedge mclk);
      chk("level", 32'(l), 32'(lvl));
      chk("vector", 32'(v), 32'(vec));
      for (int n = 0; n < 20 && isr.valid !== 1'b1; n++) @(posedge mclk);
      chk("isr", {16'h0, rom(v), rom(v + 8'h1)}, 32'(isr.addr));
      @(posedge mclk);
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge mclk);
      nrst <= 1;
      @(posedge mclk);
      chk("req", 32'h0, 32'(req));
      chk("irq", 32'h0, 32'(irq));
      foreach (rows[i]) begin
         if (rows[i].wr) bus(1, rows[i].a, rows[i].d);
         bus(0, rows[i].a, 0);
         chk("reg", rows[i].q, q);
      end
      $display("test registers done");
      bus(1, OFS_LEVEL_MASK, 32'hf7);
      pulse(24'h000060, 1);
      repeat (6) @(posedge mclk);
      chk("req", 32'h0, 32'(req));
      chk("irq", 32'h1, 32'(irq));
      bus(1, OFS_LEVEL_MASK, 32'hff);
      service(3'h3, 8'hf0);
      bus(0, OFS_SRC_PEND, 0);
      chk("pend", 32'h20, q);
      service(3'h3, 8'hf2);
      bus(0, OFS_TIMER2, 0);
      chk("t2", 32'h07, q);
      bus(1, OFS_TIMER2, 32'h06);
      bus(0, OFS_TIMER2, 0);
      chk("t2", 32'h06, q);
      bus(1, OFS_INT_STAT, 32'h7);
      chk("irq", 32'h0, 32'(irq));
      $display("test timer2 done");
      slow <= 1;
      pulse(24'h004001, 0);
      pulse('0, 1);
      di <= 1;
      @(posedge mclk);
      di <= 0;
      repeat (4) @(posedge mclk);
      chk("req", 32'h0, 32'(req));
      service(3'h6, 8'he0);
      bus(1, OFS_SRC_PEND, 32'h4000);
      service(3'h0, 8'hfc);
      pulse(24'h800000, 0);
      chk("sysrst", 32'h1, 32'(sysrst));
      $display("test level order done");
      give_verdict();
   end
endmodule // testbench
`default_nettype wire
